// *** logic/ensr_regs.sv ***
// Result, status, peak-hold and enable register bank of the sensor.
// Assumes an I2C slave engine on i_clk presents byte requests with a pointer.
//
// Function
// - Temperature result is 16 bits, two LSBs zero
// - Humidity result is 16 bits, two LSBs zero
// - Temperature code scales by 165 minus 40
// - Humidity code scales by 100 over 65536
// - Status bits 7..3 hold five flags, rest zero
// - Done flag set on conversion, cleared by result or status reads
// - Temperature-low flag set per configuration
// - Temperature-high flag set per configuration
// - Humidity-high flag set per configuration
// - Humidity-low flag set per configuration
// - Status read clears the four threshold flags
// - Alert pin follows flags per configuration
// - Temperature peak register, zeroed at reset
// - Humidity peak register, zeroed at reset
// - Peaks frozen during automatic sampling mode
// - Temperature peak byte scales by 165 minus 40
// - Humidity peak byte scales by 100 over 256
// - Enable register bits 7..3, rest reserved
// - Each enable gates its source, reset zero
// - Pointer auto-increments after each byte
`timescale 1ns/10ps
`default_nettype none
module ensr_regs import ensr_pkg::*; (
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	input  wire logic       i_soft_reset,
	input  wire logic       i_auto_mode,
	input  wire logic       i_alert_enable,
	input  wire logic       i_alert_polarity,
	input  wire logic       i_alert_level_mode,
	input  wire ensr_conv_t i_conv,
	input  wire ensr_thr_t  i_thr,
	input  wire logic       i_ptr_load,
	input  wire logic [7:0] i_ptr_value,
	input  wire logic       i_rd,
	input  wire logic       i_wr,
	input  wire logic [7:0] i_wdata,
	output logic      [7:0] o_rdata,
	output logic            o_nack,
	output logic      [7:0] o_pointer,
	output logic            o_alert_pin
);
	logic [15:0]   temp_r;
	logic [15:0]   hum_r;
	logic [7:0]    ptr_r;
	logic [7:0]    ptr_nxt;
	logic [7:0]    rdata_r;
	logic [7:0]    rdata_nxt;
	logic          nack_r;
	logic          alert_r;
	logic [4:0]    en_r;
	logic [4:0]    flags;
	logic [4:0]    flag_set;
	logic [4:0]    flag_clr;
	logic [7:0]    tpeak;
	logic [7:0]    hpeak;
	logic          mapped;
	logic          rd_flags;
	logic          rd_result;
	logic          wr_tpeak;
	logic          wr_hpeak;
	logic          live;

	assign mapped    = ptr_r <= ENSR_ADDR_LAST;
	assign rd_flags  = i_rd && ptr_r == ENSR_ADDR_FLAGS;
	assign rd_result = i_rd && ptr_r <= ENSR_ADDR_HUM_HI;
	assign wr_tpeak  = i_wr && ptr_r == ENSR_ADDR_TPEAK;
	assign wr_hpeak  = i_wr && ptr_r == ENSR_ADDR_HPEAK;

	// Result latch: 14 significant bits, low two bits forced zero
	always_ff @(posedge i_clk) begin
		if (i_reset || i_soft_reset) begin
			temp_r <= ENSR_RESULT_RESET;
		end else if (i_conv.valid && i_conv.has_temp) begin
			temp_r <= {i_conv.temp, ENSR_RESULT_ZERO_LSBS};
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset || i_soft_reset) begin
			hum_r <= ENSR_RESULT_RESET;
		end else if (i_conv.valid && i_conv.has_hum) begin
			hum_r <= {i_conv.hum, ENSR_RESULT_ZERO_LSBS};
		end
	end

	// Threshold compare results arrive already qualified by the configuration
	always_comb begin
		flag_set              = '0;
		flag_set[ENSR_F_DONE] = i_conv.valid;
		flag_set[ENSR_F_TH]   = i_thr.raw[ENSR_F_TH];
		flag_set[ENSR_F_TL]   = i_thr.raw[ENSR_F_TL];
		flag_set[ENSR_F_HH]   = i_thr.raw[ENSR_F_HH];
		flag_set[ENSR_F_HL]   = i_thr.raw[ENSR_F_HL];
	end

	always_comb begin
		flag_clr              = {ENSR_NUM_FLAGS{rd_flags}};
		flag_clr[ENSR_F_DONE] = rd_flags || rd_result;
		if (i_soft_reset) begin
			flag_clr = '1;
		end
	end

	ensr_flags #(
		.N (ENSR_NUM_FLAGS)
	) u_flags (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_set   (flag_set),
		.i_clr   (flag_clr),
		.o_flags (flags)
	);

	// Peak tracking is paused in automatic mode, matching the documented limitation
	ensr_peak #(
		.W (ENSR_RESULT_SIG)
	) u_tpeak (
		.i_clk    (i_clk),
		.i_reset  (i_reset),
		.i_clear  (i_soft_reset),
		.i_track  (!i_auto_mode),
		.i_sample (i_conv.valid && i_conv.has_temp),
		.i_value  (i_conv.temp),
		.i_wr     (wr_tpeak),
		.i_wdata  (i_wdata),
		.o_peak   (tpeak)
	);

	ensr_peak #(
		.W (ENSR_RESULT_SIG)
	) u_hpeak (
		.i_clk    (i_clk),
		.i_reset  (i_reset),
		.i_clear  (i_soft_reset),
		.i_track  (!i_auto_mode),
		.i_sample (i_conv.valid && i_conv.has_hum),
		.i_value  (i_conv.hum),
		.i_wr     (wr_hpeak),
		.i_wdata  (i_wdata),
		.o_peak   (hpeak)
	);

	// Enable register; reserved bits are not stored
	always_ff @(posedge i_clk) begin
		if (i_reset || i_soft_reset) begin
			en_r <= ENSR_FLAGS_RESET;
		end else if (i_wr && ptr_r == ENSR_ADDR_ENABLES) begin
			en_r <= i_wdata[7:3];
		end
	end

	// Pointer: loaded by the address byte, then advances per data byte
	always_comb begin
		ptr_nxt = ptr_r;
		if (i_ptr_load) begin
			ptr_nxt = i_ptr_value;
		end else if (i_rd || i_wr) begin
			ptr_nxt = ptr_r + 8'h01;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ptr_r <= ENSR_BYTE_RESET;
		end else begin
			ptr_r <= ptr_nxt;
		end
	end

	// Read data; low bytes first by host convention, no shadow latch kept
	always_comb begin
		rdata_nxt = ENSR_BYTE_RESET;
		case (ptr_r)
			ENSR_ADDR_TEMP_LO: rdata_nxt = temp_r[7:0];
			ENSR_ADDR_TEMP_HI: rdata_nxt = temp_r[15:8];
			ENSR_ADDR_HUM_LO:  rdata_nxt = hum_r[7:0];
			ENSR_ADDR_HUM_HI:  rdata_nxt = hum_r[15:8];
			ENSR_ADDR_FLAGS:   rdata_nxt = {flags, ENSR_RSVD_BITS};
			ENSR_ADDR_TPEAK:   rdata_nxt = tpeak;
			ENSR_ADDR_HPEAK:   rdata_nxt = hpeak;
			ENSR_ADDR_ENABLES: rdata_nxt = {en_r, ENSR_RSVD_BITS};
			default:           rdata_nxt = ENSR_BYTE_RESET;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rdata_r <= ENSR_BYTE_RESET;
		end else if (i_rd) begin
			rdata_r <= rdata_nxt;
		end
	end

	// Unused or read-only targets are refused so the engine can NACK
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			nack_r <= 1'b0;
		end else begin
			nack_r <= (i_rd && !mapped) ||
			          (i_wr && (!mapped || ptr_r <= ENSR_ADDR_FLAGS));
		end
	end

	// Alert: enabled flags OR-ed; pulse mode marks only a new flag edge
	logic [4:0] gated;
	logic [4:0] gated_q;
	logic       alert_nxt;
	assign gated = flags & en_r;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			gated_q <= ENSR_FLAGS_RESET;
		end else begin
			gated_q <= gated;
		end
	end

	always_comb begin
		if (i_alert_level_mode) begin
			alert_nxt = |gated;
		end else begin
			alert_nxt = |(gated & ~gated_q);
		end
		alert_nxt = i_alert_enable && alert_nxt;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			alert_r <= 1'b0;
		end else begin
			alert_r <= alert_nxt ^ !i_alert_polarity;
		end
	end

	assign o_rdata     = rdata_r;
	assign o_nack      = nack_r;
	assign o_pointer   = ptr_r;
	assign o_alert_pin = alert_r;
endmodule : ensr_regs
`default_nettype wire

// *** logic/ensr_pkg.sv ***
// Package for the sensor result, status and peak-hold register bank.
// Assumes the byte register access port comes from an I2C slave engine on i_clk.
`default_nettype none
package ensr_pkg;
	localparam logic [7:0] ENSR_ADDR_TEMP_LO  = 8'h00;
	localparam logic [7:0] ENSR_ADDR_TEMP_HI  = 8'h01;
	localparam logic [7:0] ENSR_ADDR_HUM_LO   = 8'h02;
	localparam logic [7:0] ENSR_ADDR_HUM_HI   = 8'h03;
	localparam logic [7:0] ENSR_ADDR_FLAGS    = 8'h04;
	localparam logic [7:0] ENSR_ADDR_TPEAK    = 8'h05;
	localparam logic [7:0] ENSR_ADDR_HPEAK    = 8'h06;
	localparam logic [7:0] ENSR_ADDR_ENABLES  = 8'h07;
	localparam logic [7:0] ENSR_ADDR_LAST     = 8'h07;
	localparam logic [7:0] ENSR_BYTE_RESET    = 8'h00;
	localparam logic [15:0] ENSR_RESULT_RESET = 16'h0000;
	localparam logic [1:0] ENSR_RESULT_ZERO_LSBS = 2'h0;
	localparam int     ENSR_RESULT_SIG     = 14;
	localparam int     ENSR_NUM_FLAGS      = 5;
	localparam logic [4:0] ENSR_FLAGS_RESET = 5'h00;
	localparam logic [2:0] ENSR_RSVD_BITS   = 3'h0;
	localparam logic [7:0] ENSR_ID_PLACEHOLDER = 8'h5a;

	// Flag order within the 5-bit flag vector; bit 4 maps to register bit 7
	localparam int ENSR_F_DONE  = 4;
	localparam int ENSR_F_TH    = 3;
	localparam int ENSR_F_TL    = 2;
	localparam int ENSR_F_HH    = 1;
	localparam int ENSR_F_HL    = 0;

	typedef struct packed {
		logic        valid;
		logic        has_temp;
		logic        has_hum;
		logic [13:0] temp;
		logic [13:0] hum;
	} ensr_conv_t;

	typedef struct packed {
		logic [ENSR_NUM_FLAGS-1:0] raw;
	} ensr_thr_t;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ensr_req_t;
endpackage : ensr_pkg
`default_nettype wire

// *** logic/ensr_peak.sv ***
// One peak detector: keeps the highest upper byte of a 14-bit result.
// Assumes samples arrive as single-cycle strobes on i_clk.
`timescale 1ns/10ps
`default_nettype none
module ensr_peak import ensr_pkg::*; #(
	parameter int W = ENSR_RESULT_SIG
) (
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	input  wire logic         i_clear,
	input  wire logic         i_track,
	input  wire logic         i_sample,
	input  wire logic [W-1:0] i_value,
	input  wire logic         i_wr,
	input  wire logic [7:0]   i_wdata,
	output logic      [7:0]   o_peak
);
	logic [7:0] peak_r;
	logic [7:0] top;
	assign top = i_value[W-1 -: 8];

	always_ff @(posedge i_clk) begin
		if (i_reset || i_clear) begin
			peak_r <= ENSR_BYTE_RESET;
		end else if (i_wr) begin
			peak_r <= i_wdata;
		end else if (i_track && i_sample && top > peak_r) begin
			peak_r <= top;
		end
	end
	assign o_peak = peak_r;
endmodule : ensr_peak
`default_nettype wire

// *** logic/ensr_flags.sv ***
// Sticky event flags with clear-on-read; set wins over a same-cycle clear.
// Assumes set and clear strobes are synchronous to i_clk.
`timescale 1ns/10ps
`default_nettype none
module ensr_flags import ensr_pkg::*; #(
	parameter int N = ENSR_NUM_FLAGS
) (
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	input  wire logic [N-1:0] i_set,
	input  wire logic [N-1:0] i_clr,
	output logic      [N-1:0] o_flags
);
	logic [N-1:0] flag_r;
	for (genvar g = 0; g < N; g++) begin : g_flag
		always_ff @(posedge i_clk) begin
			if (i_reset) begin
				flag_r[g] <= 1'b0;
			end else if (i_set[g]) begin
				flag_r[g] <= 1'b1;
			end else if (i_clr[g]) begin
				flag_r[g] <= 1'b0;
			end
		end
	end
	assign o_flags = flag_r;
endmodule : ensr_flags
`default_nettype wire

// *** verif/ensr_regs_sva.sv ***
// Port checker of the register bank.
// Assumes one clock and a sync reset; bound to ensr_regs.
`timescale 1ns/10ps
`default_nettype none
module ensr_regs_sva import ensr_pkg::*; (
	input wire logic       i_clk,
	input wire logic       i_reset,
	input wire logic       i_soft_reset,
	input wire logic       i_auto_mode,
	input wire logic       i_alert_enable,
	input wire logic       i_alert_polarity,
	input wire logic       i_alert_level_mode,
	input wire ensr_conv_t i_conv,
	input wire ensr_thr_t  i_thr,
	input wire logic       i_ptr_load,
	input wire logic [7:0] i_ptr_value,
	input wire logic       i_rd,
	input wire logic       i_wr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] o_rdata,
	input wire logic       o_nack,
	input wire logic [7:0] o_pointer,
	input wire logic       o_alert_pin
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	wire logic [4:0] sets = {i_conv.valid, i_thr.raw[3:0]};
	wire logic       quiet = sets == 5'h00 && !i_soft_reset;
	sequence s_st; i_rd && !i_ptr_load && !i_soft_reset && o_pointer == 8'h04; endsequence
	sequence s_gap; (!i_rd && !i_soft_reset) [*2]; endsequence
	property p_load; i_ptr_load |=> o_pointer == $past(i_ptr_value); endproperty
	property p_inc; (i_rd || i_wr) && !i_ptr_load |=> o_pointer == $past(o_pointer) + 8'h01; endproperty
	property p_nack; !i_ptr_load && (i_rd && o_pointer > 8'h07 || i_wr && o_pointer < 8'h05) |=> o_nack; endproperty
	property p_lsb; i_rd && !i_ptr_load && o_pointer[7:2] == 6'h00 && !o_pointer[0] |=> o_rdata[1:0] == 2'h0; endproperty
	property p_rsvd; s_st |=> o_rdata[2:0] == 3'h0; endproperty
	property p_seen(int b); sets[b] && !i_soft_reset ##1 s_gap ##1 s_st |=> o_rdata[3 + b]; endproperty
	property p_clr; s_st ##0 quiet ##1 quiet [*2] ##1 s_st ##0 quiet |=> o_rdata[7:3] == 5'h00; endproperty
	property p_done; i_rd && !i_ptr_load && o_pointer < 8'h04 && quiet ##1 quiet [*2] ##1 s_st |=> !o_rdata[7];
	endproperty
	property p_win; s_st ##0 i_thr.raw[0] ##1 s_gap ##1 s_st |=> o_rdata[3]; endproperty
	a_load: assert property (p_load) else $error("pointer not loaded");
	a_inc: assert property (p_inc) else $error("pointer not advanced");
	a_nack: assert property (p_nack) else $error("refusal not flagged");
	a_lsb: assert property (p_lsb) else $error("result low bits set");
	a_rsvd: assert property (p_rsvd) else $error("reserved status bits set");
	a_clr: assert property (p_clr) else $error("flags survive status read");
	a_done: assert property (p_done) else $error("done survives result read");
	a_win: assert property (p_win) else $error("same cycle set lost");
	for (genvar b = 0; b < 5; b++) begin : g_seen
		a_seen: assert property (p_seen(b)) else $error("flag not reported");
	end
endmodule : ensr_regs_sva
bind ensr_regs ensr_regs_sva i_sva (.*);
`default_nettype wire

// *** verif/ensr_host.sv ***
// Host stand-in issuing byte requests at the pointer.
// Assumes answers registered one cycle after the request edge.
`timescale 1ns/10ps
`default_nettype none
module ensr_host (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_nack,
	output logic            o_ptr_load,
	output logic      [7:0] o_ptr_value,
	output logic            o_rd,
	output logic            o_wr,
	output logic      [7:0] o_wdata
);
	logic [7:0] q [9];
	logic       nk [9];
	initial begin
		{o_ptr_load, o_ptr_value, o_rd, o_wr, o_wdata} = '0;
	end
	task automatic point(input logic [7:0] a);
		@(posedge i_clk) #1 o_ptr_load = 1'b1;
		o_ptr_value = a;
		@(posedge i_clk) #1 o_ptr_load = 1'b0;
	endtask : point
	// Reads upward, so a low result byte always goes before its high byte
	task automatic burst(input logic [7:0] a, input int n);
		point(a);
		o_rd = 1'b1;
		for (int k = 0; k < n; k++) begin
			@(posedge i_clk) #1 q[k] = i_rdata;
			nk[k] = i_nack;
			o_rd = k < n - 1;
		end
	endtask : burst
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		point(a);
		o_wr = 1'b1;
		o_wdata = d;
		@(posedge i_clk) #1 o_wr = 1'b0;
		o_wdata = ~d;
		nk[0] = i_nack;
	endtask : put
endmodule : ensr_host
`default_nettype wire

// *** verif/test_env_sensor_result_status_regs.sv ***
// Self-checking bench of the result/status register bank.
// Assumes the host stand-in ensr_host and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module test_env_sensor_result_status_regs import ensr_pkg::*; ();
	logic       i_clk = 1'b0;
	logic       i_reset = 1'b1;
	logic       soft_reset = 1'b0;
	logic       auto_mode = 1'b0;
	logic       alert_en = 1'b0;
	logic       alert_pol = 1'b1;
	logic       alert_lvl = 1'b1;
	logic       ptr_load, rd, wr, nack, alert;
	logic [7:0] ptr_value, wdata, rdata, pointer;
	ensr_conv_t conv = '0;
	ensr_thr_t  thr = '0;
	int         errors = 0;
	int         checks_done = 0;
	always #2.5 i_clk = ~i_clk;
	ensr_regs i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_soft_reset(soft_reset), .i_auto_mode(auto_mode),
		.i_alert_enable(alert_en), .i_alert_polarity(alert_pol), .i_alert_level_mode(alert_lvl), .i_conv(conv),
		.i_thr(thr), .i_ptr_load(ptr_load), .i_ptr_value(ptr_value), .i_rd(rd), .i_wr(wr), .i_wdata(wdata),
		.o_rdata(rdata), .o_nack(nack), .o_pointer(pointer), .o_alert_pin(alert));
	ensr_host i_host (.i_clk(i_clk), .i_rdata(rdata), .i_nack(nack), .o_ptr_load(ptr_load),
		.o_ptr_value(ptr_value), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude;
		if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		i_host.burst(a, 1);
		chk(i_host.q[0], e);
	endtask : rd_chk
	task automatic convert(input logic [13:0] t, input logic [13:0] h);
		@(posedge i_clk) #1 conv = {3'b111, t, h};
		@(posedge i_clk) #1 conv = '0;
	endtask : convert
	task automatic thresh(input logic [3:0] m);
		@(posedge i_clk) #1 thr = {1'b0, m};
		@(posedge i_clk) #1 thr = '0;
	endtask : thresh
	// The alert pin is registered, so give it a few edges before looking
	task automatic alert_is(input logic e);
		repeat (3) @(posedge i_clk);
		#1 chk({7'h00, alert}, {7'h00, e});
	endtask : alert_is
	task automatic t_reset;
		i_host.burst(8'h00, 9);
		for (int k = 0; k < 9; k++) chk(i_host.q[k], 8'h00);
		chk({7'h00, i_host.nk[8]}, 8'h01);
	endtask : t_reset
	task automatic t_conv;
		convert(14'h2abc, 14'h1234);
		rd_chk(8'h04, 8'h80);
		convert(14'h2abc, 14'h1234);
		i_host.burst(8'h00, 4);
		chk(i_host.q[0], 8'hf0);
		chk(i_host.q[1], 8'haa);
		chk(i_host.q[2], 8'hd0);
		chk(i_host.q[3], 8'h48);
		rd_chk(8'h04, 8'h00);
	endtask : t_conv
	task automatic t_flags;
		for (int b = 0; b < 4; b++) begin
			thresh(4'h1 << b);
			rd_chk(8'h04, 8'h08 << b);
		end
		rd_chk(8'h04, 8'h00);
		fork
			i_host.burst(8'h04, 1);
			begin
				repeat (2) @(posedge i_clk);
				#1 thr = 5'h01;
				@(posedge i_clk) #1 thr = '0;
			end
		join
		rd_chk(8'h04, 8'h08);
	endtask : t_flags
	task automatic t_peak;
		convert(14'h0100, 14'h3fff);
		auto_mode = 1'b1;
		convert(14'h3fff, 14'h0000);
		repeat (2) @(posedge i_clk);
		#1 auto_mode = 1'b0;
		i_host.burst(8'h05, 2);
		chk(i_host.q[0], 8'haa);
		chk(i_host.q[1], 8'hff);
		@(posedge i_clk) #1 soft_reset = 1'b1;
		@(posedge i_clk) #1 soft_reset = 1'b0;
		i_host.burst(8'h04, 4);
		for (int k = 0; k < 4; k++) chk(i_host.q[k], 8'h00);
	endtask : t_peak
	task automatic t_write;
		i_host.put(8'h07, 8'hff);
		rd_chk(8'h07, 8'hf8);
		i_host.put(8'h05, 8'h33);
		rd_chk(8'h05, 8'h33);
		i_host.put(8'h01, 8'h55);
		chk({7'h00, i_host.nk[0]}, 8'h01);
		rd_chk(8'h01, 8'h00);
	endtask : t_write
	task automatic t_alert;
		i_host.put(8'h07, 8'h80);
		alert_en = 1'b1;
		thresh(4'h8);
		alert_is(1'b0);
		convert(14'h0001, 14'h0001);
		alert_is(1'b1);
		rd_chk(8'h04, 8'hc0);
		alert_is(1'b0);
		// Active-low pin idles high and drops while the enabled flag stands
		alert_pol = 1'b0;
		alert_is(1'b1);
		convert(14'h0001, 14'h0001);
		alert_is(1'b0);
		rd_chk(8'h04, 8'h80);
		alert_pol = 1'b1;
		alert_lvl = 1'b0;
		alert_is(1'b0);
		// Pulse mode marks the new flag for exactly one cycle
		convert(14'h0001, 14'h0001);
		@(posedge i_clk) #1 chk({7'h00, alert}, 8'h01);
		@(posedge i_clk) #1 chk({7'h00, alert}, 8'h00);
	endtask : t_alert
	initial begin
		repeat (3) @(posedge i_clk);
		#1 i_reset = 1'b0;
		t_reset();
		t_conv();
		t_flags();
		t_peak();
		t_write();
		t_alert();
		conclude();
	end
	// The whole run needs about 130 cycles; this leaves ample margin
	initial begin
		#20000;
		errors++;
		conclude();
	end
endmodule : test_env_sensor_result_status_regs
`default_nettype wire
